// ===== rtl/dlg_regs.svh
`ifndef DLG_REGS_SVH
`define DLG_REGS_SVH

// Register byte addresses; the block decodes the full 32-bit address
`define DLG_DIR_BANK2_ADDR    32'h40e00014
`define DLG_SET_BANK2_ADDR    32'h40e00020
`define DLG_CLR_BANK2_ADDR    32'h40e0002c
`define DLG_PAD_CTRL_ADDR     32'h40e104d0

// Field positions
`define DLG_LED_BIT           15
`define DLG_FSEL_LSB          0
`define DLG_FSEL_MSB          2

// Reset values
`define DLG_DIR_RST           32'h00000000
`define DLG_LVL_RST           32'hffffffff
`define DLG_PAD_RST           32'h00000000
`define DLG_FSEL_GPIO         3'h0

`endif

// ===== rtl/dlg_pkg.sv
package dlg_pkg;
  typedef logic [31:0] dlg_word_t;
  typedef enum logic [2:0] {
    DLG_SEL_NONE = 3'h0,
    DLG_SEL_DIR  = 3'h1,
    DLG_SEL_SET  = 3'h3,
    DLG_SEL_CLR  = 3'h2,
    DLG_SEL_PAD  = 3'h6
  } dlg_sel_t;
endpackage

// ===== rtl/dlg_gpio.sv
`timescale 1ns/1ps
`include "dlg_regs.svh"
// Notes on behaviour
// - The debug indicator lights only while the pin is an output driven low.
// - The pad control register holds a 3-bit function select in bits 2:0; zero selects GPIO.
// - Bit 15 of the bank-2 direction register set to one makes the LED pin an output.
// - Writing one to bit 15 of the bank-2 level-set register drives the pin high.
// - Writing one to bit 15 of the bank-2 level-clear register drives the pin low.
module dlg_gpio (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             pin_o,
  output logic             pin_oe_o,
  output logic             led_on_o
);

  // ==========================================================
  // Address decode
  function automatic dlg_pkg::dlg_sel_t decode(input logic [31:0] a);
    case (a)
      `DLG_DIR_BANK2_ADDR: decode = dlg_pkg::DLG_SEL_DIR;
      `DLG_SET_BANK2_ADDR: decode = dlg_pkg::DLG_SEL_SET;
      `DLG_CLR_BANK2_ADDR: decode = dlg_pkg::DLG_SEL_CLR;
      `DLG_PAD_CTRL_ADDR:  decode = dlg_pkg::DLG_SEL_PAD;
      default:             decode = dlg_pkg::DLG_SEL_NONE;
    endcase
  endfunction

  dlg_pkg::dlg_sel_t sel;
  assign sel = decode(addr_i);

  // ==========================================================
  // Access strobes
  // Strobes carry no enable term; every register group applies ce_i itself,
  // so one low enable freezes all flip-flops, read data included.
  logic wr_dir;
  logic wr_set;
  logic wr_clr;
  logic wr_pad;
  logic rd_dir;
  logic rd_pad;

  assign wr_dir = wr_i && sel == dlg_pkg::DLG_SEL_DIR;
  assign wr_set = wr_i && sel == dlg_pkg::DLG_SEL_SET;
  assign wr_clr = wr_i && sel == dlg_pkg::DLG_SEL_CLR;
  assign wr_pad = wr_i && sel == dlg_pkg::DLG_SEL_PAD;
  assign rd_dir = rd_i && sel == dlg_pkg::DLG_SEL_DIR;
  assign rd_pad = rd_i && sel == dlg_pkg::DLG_SEL_PAD;

  // ==========================================================
  // Direction register
  dlg_pkg::dlg_word_t dir_r;
  dlg_pkg::dlg_word_t dir_nxt;

  always_comb begin
    dir_nxt = dir_r;
    if (wr_dir) begin
      dir_nxt = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      dir_r <= `DLG_DIR_RST;
    end else if (ce_i) begin
      dir_r <= dir_nxt;
    end
  end

  // ==========================================================
  // Level register
  // Levels reset to all ones, so the active-low indicator stays dark
  // until software clears the LED bit.
  dlg_pkg::dlg_word_t lvl_r;
  dlg_pkg::dlg_word_t lvl_nxt;

  always_comb begin
    lvl_nxt = lvl_r;
    if (wr_set) begin
      lvl_nxt = lvl_r | wdata_i;
    end
    if (wr_clr) begin
      lvl_nxt = lvl_r & ~wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lvl_r <= `DLG_LVL_RST;
    end else if (ce_i) begin
      lvl_r <= lvl_nxt;
    end
  end

  // ==========================================================
  // Pad control register
  dlg_pkg::dlg_word_t pad_r;
  dlg_pkg::dlg_word_t pad_nxt;

  always_comb begin
    pad_nxt = pad_r;
    if (wr_pad) begin
      pad_nxt = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pad_r <= `DLG_PAD_RST;
    end else if (ce_i) begin
      pad_r <= pad_nxt;
    end
  end

  // ==========================================================
  // Read data
  dlg_pkg::dlg_word_t rdata_r;
  dlg_pkg::dlg_word_t rdata_nxt;

  // Set, clear and unmapped addresses read as zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (rd_dir) begin
      rdata_nxt = dir_r;
    end
    if (rd_pad) begin
      rdata_nxt = pad_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_r <= 32'h00000000;
    end else if (ce_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Pin drive
  // Pin is only driven when the pad is in GPIO function, so another
  // function never fights the LED output.
  logic gpio_fn;
  assign gpio_fn  = pad_r[`DLG_FSEL_MSB:`DLG_FSEL_LSB] == `DLG_FSEL_GPIO;
  assign rdata_o  = rdata_r;
  assign pin_o    = lvl_r[`DLG_LED_BIT];
  assign pin_oe_o = gpio_fn & dir_r[`DLG_LED_BIT];
  assign led_on_o = pin_oe_o & ~pin_o;

  // ==========================================================
  // Checks
  sequence clr_write_s;
    wr_i && ce_i && sel == dlg_pkg::DLG_SEL_CLR && wdata_i[`DLG_LED_BIT];
  endsequence

  sequence set_write_s;
    wr_i && ce_i && sel == dlg_pkg::DLG_SEL_SET && wdata_i[`DLG_LED_BIT];
  endsequence

  led_lit_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    led_on_o == (gpio_fn && dir_r[`DLG_LED_BIT] && !lvl_r[`DLG_LED_BIT]))
    else $error("led state wrong");

  set_high_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    set_write_s |=> pin_o && !led_on_o)
    else $error("set did not drive high");

  clr_low_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    clr_write_s ##1 pin_oe_o |-> led_on_o)
    else $error("clear did not light led");

  dir_out_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_i && ce_i && sel == dlg_pkg::DLG_SEL_DIR) |=>
      dir_r[`DLG_LED_BIT] == $past(wdata_i[`DLG_LED_BIT]))
    else $error("direction not stored");

  fsel_gpio_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_pad && ce_i && wdata_i[`DLG_FSEL_MSB:`DLG_FSEL_LSB] != `DLG_FSEL_GPIO) |=> !pin_oe_o)
    else $error("pin driven outside gpio function");

  zero_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_i && ce_i && (sel == dlg_pkg::DLG_SEL_SET || sel == dlg_pkg::DLG_SEL_CLR)
      && !wdata_i[`DLG_LED_BIT]) |=> $stable(pin_o))
    else $error("zero bit changed level");

  read_dir_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rd_i && ce_i && sel == dlg_pkg::DLG_SEL_DIR && !wr_i) |=> rdata_o == $past(dir_r))
    else $error("direction read back wrong");

  frozen_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !ce_i |=> $stable(lvl_r) && $stable(dir_r) && $stable(pad_r) && $stable(rdata_r))
    else $error("state moved with clock enable low");

  sequence pad_write_s;
    wr_pad && ce_i;
  endsequence

  sequence pad_read_s;
    rd_pad && ce_i && !wr_i;
  endsequence

  sequence stray_write_s;
    wr_i && ce_i && sel == dlg_pkg::DLG_SEL_NONE;
  endsequence

  pad_store_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pad_write_s |=> pad_r == $past(wdata_i))
    else $error("pad control not stored");

  read_pad_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pad_read_s |=> rdata_o == $past(pad_r))
    else $error("pad control read back wrong");

  read_idle_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && !rd_dir && !rd_pad) |=> rdata_o == 32'h00000000)
    else $error("read data not cleared");

  stray_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    stray_write_s |=> $stable(dir_r) && $stable(lvl_r) && $stable(pad_r))
    else $error("unmapped write changed state");

  reset_dark_a: assert property (@(posedge clk_i)
    !resetn_i |=> pin_o && !pin_oe_o && !led_on_o)
    else $error("led not dark after reset");

endmodule

// ===== bench/dlg_led_model.sv
`timescale 1ns/1ps
module dlg_led_model (
  input  wire logic pin_i,
  input  wire logic oe_i,
  output logic      lit_o
);
  // Active-low indicator: a released pin leaves it dark
  assign lit_o = oe_i & ~pin_i;
endmodule

// ===== bench/tb_debug_led_gpio_control.sv
`timescale 1ns/1ps
`include "dlg_regs.svh"
module tb_debug_led_gpio_control;
  logic        clk_i, resetn_i, ce_i, wr_i, rd_i, pin_o, pin_oe_o, led_on_o, lit;
  logic [31:0] addr_i, wdata_i, rdata_o, dir, lvl, pad, rdv;
  logic [31:0] amap [5] = '{`DLG_DIR_BANK2_ADDR, `DLG_SET_BANK2_ADDR,
    `DLG_CLR_BANK2_ADDR, `DLG_PAD_CTRL_ADDR, 32'h40e00018};
  int          errors, comparisons, cyc, k;
  integer      seed = 45118;
  dlg_gpio i_dlg_gpio (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .led_on_o(led_on_o));
  dlg_led_model i_dlg_led_model (.pin_i(pin_o), .oe_i(pin_oe_o), .lit_o(lit));
  // ==========================================
  // Clock, checks and bus tasks
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic pins();
    logic lit_exp;
    lit_exp = dir[15] && pad[2:0] == 3'h0 && !lvl[15];
    chk("pin", {31'h0, pin_o}, {31'h0, lvl[15]});
    chk("oe", {31'h0, pin_oe_o}, {31'h0, dir[15] && pad[2:0] == 3'h0});
    chk("led", {31'h0, led_on_o}, {31'h0, lit_exp});
    chk("lit", {31'h0, lit}, {31'h0, lit_exp});
    chk("rdata idle", rdata_o, 32'h0);
  endtask
  // Model follows only writes taken with the enable high; checks wait for
  // the falling edge so the registers have settled
  task automatic wr(input logic [31:0] a, d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
    if (ce_i) begin
      case (a)
        `DLG_DIR_BANK2_ADDR: dir = d;
        `DLG_SET_BANK2_ADDR: lvl = lvl | d;
        `DLG_CLR_BANK2_ADDR: lvl = lvl & ~d;
        `DLG_PAD_CTRL_ADDR: pad = d;
        default: ;
      endcase
    end
    @(negedge clk_i);
    pins();
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [31:0] a);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
    @(negedge clk_i);
    rdv = rdata_o;
    chk("rdata", rdata_o, a == `DLG_DIR_BANK2_ADDR ? dir :
      a == `DLG_PAD_CTRL_ADDR ? pad : 32'h0);
    @(posedge clk_i);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    resetn_i = 1'b0;
    ce_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    dir = `DLG_DIR_RST;
    lvl = `DLG_LVL_RST;
    pad = `DLG_PAD_RST;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'h1;
    @(negedge clk_i);
    pins();
    @(posedge clk_i);
    foreach (amap[i]) rd(amap[i]);
    $display("reset test done");
    rd(`DLG_DIR_BANK2_ADDR);
    wr(`DLG_DIR_BANK2_ADDR, rdv | 32'h8000);
    wr(`DLG_CLR_BANK2_ADDR, 32'h8000);
    wr(`DLG_SET_BANK2_ADDR, 32'h7fff);
    rd(`DLG_PAD_CTRL_ADDR);
    wr(`DLG_PAD_CTRL_ADDR, rdv | 32'h5);
    wr(`DLG_PAD_CTRL_ADDR, rdv & ~32'h7);
    wr(`DLG_SET_BANK2_ADDR, 32'h8000);
    $display("led test done");
    ce_i <= 1'h0;
    wr(`DLG_CLR_BANK2_ADDR, 32'h8000);
    wr(`DLG_DIR_BANK2_ADDR, 32'h0);
    ce_i <= 1'h1;
    rd(`DLG_DIR_BANK2_ADDR);
    $display("freeze test done");
    resetn_i <= 1'h0;
    @(posedge clk_i);
    resetn_i <= 1'h1;
    dir = `DLG_DIR_RST;
    lvl = `DLG_LVL_RST;
    pad = `DLG_PAD_RST;
    @(negedge clk_i);
    pins();
    @(posedge clk_i);
    rd(`DLG_PAD_CTRL_ADDR);
    $display("reset again test done");
    repeat (80) begin
      k = $unsigned($random(seed)) % 5;
      if ($random(seed) % 2) wr(amap[k], $random(seed));
      else rd(amap[k]);
    end
    $display("random test done");
    wrap_up();
  end
endmodule
